// File: hw/hbp_pkg.sv
`default_nettype none
package hbp_pkg;

    // Host pin address and internal register address widths
    localparam int HBP_ADDR_W = 5;
    localparam int HBP_IREG_AW = 24;

    // Avalon register byte offsets
    localparam logic [3:0] AV_SETUP_OFS = 4'h0;
    localparam logic [3:0] AV_STATUS_OFS = 4'h4;
    localparam logic [3:0] AV_HOSTCFG_OFS = 4'h8;

    // Port setup field layout (polarity bit 1 = active high)
    typedef struct packed {
        logic bus16;
        logic rw_mode;
        logic wr_pol;
        logic rd_pol;
        logic cs_pol;
        logic wait_pol;
    } hbp_setup_s;
    localparam logic [5:0] SETUP_RESET = 6'h3E;

    // Host-side configuration dword, bit 0 selects big endian
    localparam int HOSTCFG_BIG_BIT = 0;
    localparam logic [31:0] HOSTCFG_RESET = 32'h0000_0000;
    localparam logic [2:0] CFG_DWORD = 3'h0;

    // Host pins as seen by the port
    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic [HBP_ADDR_W-1:0] addr;
        logic [15:0] d;
    } hbp_pin_in_s;

    typedef struct packed {
        logic [15:0] d;
        logic [1:0] d_oe;
        logic wait_ack;
    } hbp_pin_out_s;

    // Internal register access port
    typedef struct packed {
        logic valid;
        logic write;
        logic [HBP_IREG_AW-1:0] addr;
        logic [31:0] wdata;
    } hbp_ireg_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } hbp_ireg_rsp_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } hbp_state_e;

    // Dword lane of a byte address under the selected endianness
    function automatic logic [1:0] hbp_lane(input logic [1:0] b, input logic big);
        return big ? ~b : b;
    endfunction : hbp_lane

    function automatic logic [1:0] hbp_first(input logic [1:0] a, input logic bus16);
        return bus16 ? {a[1], 1'b0} : a;
    endfunction : hbp_first

    // Lanes touched by one host access
    function automatic logic [3:0] hbp_mask(input logic [1:0] a, input logic bus16, input logic big);
        logic [3:0] m;
        m = 4'h1 << hbp_lane(hbp_first(a, bus16), big);
        if (bus16) begin
            m = m | (4'h1 << hbp_lane(hbp_first(a, bus16) | 2'h1, big));
        end
        return m;
    endfunction : hbp_mask

    function automatic logic [15:0] hbp_get(input logic [31:0] dw, input logic [1:0] a,
                                            input logic bus16, input logic big);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = dw[{hbp_lane(hbp_first(a, bus16), big), 3'h0} +: 8];
        hi = bus16 ? dw[{hbp_lane(hbp_first(a, bus16) | 2'h1, big), 3'h0} +: 8] : 8'h00;
        return {hi, lo};
    endfunction : hbp_get

    function automatic logic [31:0] hbp_put(input logic [31:0] dw, input logic [15:0] d,
                                            input logic [1:0] a, input logic bus16, input logic big);
        logic [31:0] r;
        r = dw;
        r[{hbp_lane(hbp_first(a, bus16), big), 3'h0} +: 8] = d[7:0];
        if (bus16) begin
            r[{hbp_lane(hbp_first(a, bus16) | 2'h1, big), 3'h0} +: 8] = d[15:8];
        end
        return r;
    endfunction : hbp_put

endpackage : hbp_pkg
`default_nettype wire

// File: hw/hbp_strobe_decode.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_strobe_decode (
    // Clock and synchronised reset
    input wire logic clk_sys,
    input wire logic rst_q_n,
    // Pins and setup
    input wire hbp_pkg::hbp_pin_in_s pins,
    input wire hbp_pkg::hbp_setup_s setup,
    // Decoded strobes
    output logic cs_level,
    output logic rd_level,
    output logic [hbp_pkg::HBP_ADDR_W-1:0] rd_addr,
    output logic rd_end,
    output logic wr_done,
    output logic [hbp_pkg::HBP_ADDR_W-1:0] wr_addr,
    output logic [15:0] wr_data
);
    import hbp_pkg::*;

    // Pin levels normalised by their polarity bits
    wire cs_on = (pins.cs == setup.cs_pol);
    wire rd_on = (pins.rd == setup.rd_pol);
    wire wr_on = (pins.wr == setup.wr_pol);

    // Separate strobes, or direction plus transfer_strobe
    wire read_now = cs_on & (setup.rw_mode ? (wr_on & ~rd_on) : rd_on);
    wire write_now = cs_on & (setup.rw_mode ? (wr_on & rd_on) : wr_on);
    logic wr_act;

    // Write data follows the bus while active; the last value stands at the trailing edge
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            cs_level <= 1'b0;
            rd_level <= 1'b0;
            rd_addr <= '0;
            rd_end <= 1'b0;
            wr_act <= 1'b0;
            wr_done <= 1'b0;
            wr_addr <= '0;
            wr_data <= 16'h0000;
        end else begin
            cs_level <= cs_on;
            rd_level <= read_now;
            rd_end <= rd_level & ~read_now;
            wr_act <= write_now;
            wr_done <= wr_act & ~write_now;
            if (read_now) begin
                rd_addr <= pins.addr;
            end
            if (write_now) begin
                wr_addr <= pins.addr;
                wr_data <= pins.d;
            end
        end
    end

endmodule : hbp_strobe_decode
`default_nettype wire

// File: hw/hbp_indexed_port.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_indexed_port #(
    parameter int NUM_INDEX = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Host bus pins
    input wire hbp_pkg::hbp_pin_in_s hb_in,
    output hbp_pkg::hbp_pin_out_s hb_out,
    // Internal register port
    output hbp_pkg::hbp_ireg_req_s ireg_req,
    input wire hbp_pkg::hbp_ireg_rsp_s ireg_rsp
);
    import hbp_pkg::*;

    localparam int KW = 2;

    // Reset release through two flip-flops
    logic rst_q1;
    logic rst_q_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q_n <= rst_q1;
        end
    end

    // Configuration and access engine state
    hbp_setup_s setup_reg;
    logic [31:0] host_cfg_reg;
    hbp_state_e state_reg;
    logic pend_reg;
    logic [KW-1:0] pend_k_reg;
    logic [31:0] pend_data_reg;
    logic [KW-1:0] cur_k_reg;

    // Per-index storage
    logic [HBP_IREG_AW-1:0] idx_reg [NUM_INDEX];
    logic [31:0] wbuf_reg [NUM_INDEX];
    logic [3:0] wmask_reg [NUM_INDEX];
    logic [31:0] rbuf_reg [NUM_INDEX];
    logic [3:0] rmask_reg [NUM_INDEX];
    logic [NUM_INDEX-1:0] rvalid_reg;

    // Strobe decoder outputs
    logic cs_level;
    logic rd_level;
    logic [HBP_ADDR_W-1:0] rd_addr;
    logic rd_end;
    logic wr_done;
    logic [HBP_ADDR_W-1:0] wr_addr;
    logic [15:0] wr_data;

    hbp_strobe_decode u_decode (
        .clk_sys(clk_sys),
        .rst_q_n(rst_q_n),
        .pins(hb_in),
        .setup(setup_reg),
        .cs_level(cs_level),
        .rd_level(rd_level),
        .rd_addr(rd_addr),
        .rd_end(rd_end),
        .wr_done(wr_done),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // Index number held in a dword address (odd = index, even nonzero = data)
    function automatic logic [KW-1:0] slot_of(input logic [2:0] dw);
        return dw[0] ? dw[2:1] : (dw[2:1] - 2'h1);
    endfunction : slot_of

    function automatic logic slot_ok(input logic [2:0] dw);
        return (dw != CFG_DWORD) && (32'(slot_of(dw)) < NUM_INDEX);
    endfunction : slot_ok

    wire big = host_cfg_reg[HOSTCFG_BIG_BIT];
    wire bus16 = setup_reg.bus16;

    // Write target decode
    wire [2:0] w_dw = wr_addr[4:2];
    wire [KW-1:0] wk = slot_of(w_dw);
    wire w_cfg = wr_done & (w_dw == CFG_DWORD);
    wire w_idx = wr_done & slot_ok(w_dw) & w_dw[0];
    wire w_dat = wr_done & slot_ok(w_dw) & ~w_dw[0];
    wire [3:0] w_mask = hbp_mask(wr_addr[1:0], bus16, big);
    wire [31:0] w_idx_new = hbp_put({8'h00, idx_reg[wk]}, wr_data, wr_addr[1:0], bus16, big);
    wire [31:0] w_dat_new = hbp_put(wbuf_reg[wk], wr_data, wr_addr[1:0], bus16, big);
    wire [3:0] w_acc = wmask_reg[wk] | w_mask;
    wire w_full = w_dat & (w_acc == 4'hF);

    // Read target decode
    wire [2:0] r_dw = rd_addr[4:2];
    wire [KW-1:0] rk = slot_of(r_dw);
    wire r_cfg = (r_dw == CFG_DWORD);
    wire r_idx = slot_ok(r_dw) & r_dw[0];
    wire r_dat = slot_ok(r_dw) & ~r_dw[0];
    wire [3:0] r_mask = hbp_mask(rd_addr[1:0], bus16, big);
    wire r_ready = ~r_dat | rvalid_reg[rk];
    wire [31:0] r_dword = r_cfg ? host_cfg_reg :
                          r_idx ? {8'h00, idx_reg[rk]} :
                          r_dat ? rbuf_reg[rk] : 32'h0000_0000;
    wire [15:0] r_word = hbp_get(r_dword, rd_addr[1:0], bus16, big);
    wire r_last = rd_end & r_dat & ((rmask_reg[rk] | r_mask) == 4'hF);

    // Internal access engine decode
    wire start_wr = (state_reg == ST_IDLE) & pend_reg;
    wire start_rd = (state_reg == ST_IDLE) & ~pend_reg & rd_level & r_dat & ~rvalid_reg[rk];
    wire fin_wr = (state_reg == ST_WRITE) & ireg_rsp.ack;
    wire fin_rd = (state_reg == ST_READ) & ireg_rsp.ack;
    wire busy_wr = pend_reg | (state_reg == ST_WRITE);

    // Internal register access engine
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            state_reg <= ST_IDLE;
            ireg_req <= '0;
            cur_k_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_wr) begin
                        state_reg <= ST_WRITE;
                        ireg_req <= {1'b1, 1'b1, idx_reg[pend_k_reg], pend_data_reg};
                        cur_k_reg <= pend_k_reg;
                    end else if (start_rd) begin
                        state_reg <= ST_READ;
                        ireg_req <= {1'b1, 1'b0, idx_reg[rk], 32'h0000_0000};
                        cur_k_reg <= rk;
                    end
                end
                ST_WRITE, ST_READ: begin
                    if (ireg_rsp.ack) begin
                        state_reg <= ST_IDLE;
                        ireg_req.valid <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    ireg_req.valid <= 1'b0;
                end
            endcase
        end
    end

    // Completed dword waits here for the engine; a new one wins over the take
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pend_reg <= 1'b0;
            pend_k_reg <= '0;
            pend_data_reg <= 32'h0000_0000;
        end else if (w_full) begin
            pend_reg <= 1'b1;
            pend_k_reg <= wk;
            pend_data_reg <= w_dat_new;
        end else if (start_wr) begin
            pend_reg <= 1'b0;
        end
    end

    // Host configuration dword, each partial write applied at once
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            host_cfg_reg <= HOSTCFG_RESET;
        end else if (w_cfg) begin
            host_cfg_reg <= hbp_put(host_cfg_reg, wr_data, wr_addr[1:0], bus16, big);
        end
    end

    // Index, assembly and read buffers per slot
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            for (int i = 0; i < NUM_INDEX; i++) begin
                idx_reg[i] <= '0;
                wbuf_reg[i] <= 32'h0000_0000;
                wmask_reg[i] <= 4'h0;
                rbuf_reg[i] <= 32'h0000_0000;
                rmask_reg[i] <= 4'h0;
            end
            rvalid_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_INDEX; i++) begin
                if (w_idx && 32'(wk) == i) begin
                    idx_reg[i] <= w_idx_new[HBP_IREG_AW-1:0];
                    wmask_reg[i] <= 4'h0;
                    rmask_reg[i] <= 4'h0;
                end
                if (w_dat && 32'(wk) == i) begin
                    wbuf_reg[i] <= w_dat_new;
                    wmask_reg[i] <= w_full ? 4'h0 : w_acc;
                end
                if (fin_rd && 32'(cur_k_reg) == i) begin
                    rbuf_reg[i] <= ireg_rsp.rdata;
                    rmask_reg[i] <= 4'h0;
                end
                if (rd_end && r_dat && 32'(rk) == i) begin
                    rmask_reg[i] <= r_last ? 4'h0 : (rmask_reg[i] | r_mask);
                end
                if ((w_idx && 32'(wk) == i) || (fin_wr && 32'(cur_k_reg) == i) ||
                    (r_last && 32'(rk) == i)) begin
                    rvalid_reg[i] <= 1'b0;
                end else if (fin_rd && 32'(cur_k_reg) == i) begin
                    rvalid_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Pin side outputs
    logic out_ok_reg;
    wire wait_on = (rd_level & ~(r_ready & out_ok_reg)) | (cs_level & busy_wr);
    wire [1:0] lanes = bus16 ? 2'b11 : 2'b01;

    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            out_ok_reg <= 1'b0;
            hb_out.d <= 16'h0000;
            hb_out.d_oe <= 2'b00;
            hb_out.wait_ack <= 1'b1;
        end else begin
            out_ok_reg <= rd_level & r_ready;
            hb_out.d <= bus16 ? r_word : {8'h00, r_word[7:0]};
            hb_out.d_oe <= rd_level ? lanes : 2'b00;
            hb_out.wait_ack <= wait_on ? setup_reg.wait_pol : ~setup_reg.wait_pol;
        end
    end

    // Avalon decode
    wire av_req = avs_read | avs_write;
    wire av_take = avs_write & ~avs_waitrequest;
    wire av_setup = (avs_address == AV_SETUP_OFS);
    wire [31:0] av_status = {24'h00_0000, 1'b0, rvalid_reg[0], 1'b0, pend_reg,
                             2'b00, state_reg};
    wire [31:0] av_rdata = av_setup ? {26'h000_0000, setup_reg} :
                           (avs_address == AV_STATUS_OFS) ? av_status :
                           (avs_address == AV_HOSTCFG_OFS) ? host_cfg_reg : 32'h0000_0000;

    // One wait state per access; write lands where waitrequest is seen low
    always_ff @(posedge clk_sys or negedge rst_q_n) begin
        if (!rst_q_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            setup_reg <= SETUP_RESET;
        end else begin
            avs_waitrequest <= ~(av_req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= av_rdata;
            end
            if (av_take && av_setup && avs_byteenable[0]) begin
                setup_reg <= avs_writedata[5:0];
            end
        end
    end

endmodule : hbp_indexed_port
`default_nettype wire

// File: test/hbp_indexed_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_indexed_port_monitor
    import hbp_pkg::*;
#(
    parameter int NUM_INDEX = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Host pins and internal port
    input wire hbp_pkg::hbp_pin_in_s hb_in,
    input wire hbp_pkg::hbp_pin_out_s hb_out,
    input wire hbp_pkg::hbp_ireg_req_s ireg_req,
    input wire hbp_pkg::hbp_ireg_rsp_s ireg_rsp
);
    hbp_setup_s cfg_reg;
    // Mirror of the setup register, taken at the accepting edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= SETUP_RESET;
        end else if (avs_write && !avs_waitrequest && avs_address == AV_SETUP_OFS && avs_byteenable[0]) begin
            cfg_reg <= avs_writedata[5:0];
        end
    end
    // Read strobe decode under the mirrored polarities and mode
    wire logic cs_act = hb_in.cs == cfg_reg.cs_pol;
    wire logic rd_sep = hb_in.rd == cfg_reg.rd_pol;
    wire logic rd_dir = hb_in.rd != cfg_reg.rd_pol && hb_in.wr == cfg_reg.wr_pol;
    wire logic rd_act = cs_act && (cfg_reg.rw_mode ? rd_dir : rd_sep);
    wire logic wait_on = hb_out.wait_ack == cfg_reg.wait_pol;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_read_held;
        rd_act [*4];
    endsequence
    sequence s_read_end;
        rd_act ##1 !rd_act;
    endsequence
    a_read_drives: assert property (s_read_held |-> hb_out.d_oe != 2'b00)
        else $error("read strobe held but data lanes not driven");
    a_drive_release: assert property (s_read_end |-> ##[1:4] hb_out.d_oe == 2'b00)
        else $error("data lanes still driven after read ended");
    a_narrow_lane: assert property (!cfg_reg.bus16 |-> !hb_out.d_oe[1])
        else $error("upper lane driven in byte mode");
    a_wide_pair: assert property (cfg_reg.bus16 |-> hb_out.d_oe != 2'b01 && hb_out.d_oe != 2'b10)
        else $error("word mode drives a single lane");
    a_wait_raise: assert property ($rose(rd_act) |-> ##[1:3] wait_on)
        else $error("wait not asserted after read start");
    a_wait_clears: assert property ($rose(rd_act) |-> ##[3:60] !wait_on)
        else $error("read data never became valid");
    a_ireg_hold: assert property (ireg_req.valid && !ireg_rsp.ack |=>
        ireg_req.valid && $stable(ireg_req.addr) && $stable(ireg_req.write))
        else $error("internal request changed before ack");
    a_ireg_drop: assert property (ireg_rsp.ack |=> !ireg_req.valid)
        else $error("internal request held after ack");
    a_av_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered");
    a_av_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
endmodule : hbp_indexed_port_monitor
bind hbp_indexed_port hbp_indexed_port_monitor #(.NUM_INDEX(NUM_INDEX)) u_mon (.clk_sys, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_waitrequest,
    .hb_in, .hb_out, .ireg_req, .ireg_rsp);
`default_nettype wire

// File: test/hbp_ireg_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_ireg_model
    import hbp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Internal register port
    input wire hbp_pkg::hbp_ireg_req_s ireg_req,
    output hbp_pkg::hbp_ireg_rsp_s ireg_rsp
);
    logic [31:0] mem [256];
    logic [23:0] last_addr;
    int delay = 1;
    int n_wr = 0;
    int cnt;
    // Preset contents so unwritten registers are not zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'h1357_9BDF ^ {4{i[7:0]}};
        end
    end
    // Answers a held request after a settable delay; idle data toggles
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ireg_rsp <= '0;
            cnt <= 0;
        end else begin
            ireg_rsp.ack <= 1'b0;
            ireg_rsp.rdata <= ~ireg_rsp.rdata;
            if (ireg_req.valid && !ireg_rsp.ack) begin
                cnt <= cnt + 1;
                if (cnt >= delay) begin
                    cnt <= 0;
                    ireg_rsp.ack <= 1'b1;
                    last_addr <= ireg_req.addr;
                    if (ireg_req.write) begin
                        mem[ireg_req.addr[7:0]] <= ireg_req.wdata;
                        n_wr <= n_wr + 1;
                    end else begin
                        ireg_rsp.rdata <= mem[ireg_req.addr[7:0]];
                    end
                end
            end
        end
    end
endmodule : hbp_ireg_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hbp_pkg::*;
    logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    hbp_pin_in_s hb_in;
    hbp_pin_out_s hb_out;
    hbp_ireg_req_s ireg_req;
    hbp_ireg_rsp_s ireg_rsp;
    hbp_setup_s cur;
    int n_fail, n_checks;
    hbp_indexed_port #(.NUM_INDEX(3)) DUT (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .hb_in, .hb_out, .ireg_req, .ireg_rsp);
    hbp_ireg_model u_regs (.clk_sys, .rst_n, .ireg_req, .ireg_rsp);
    // Clock at 40 MHz
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : check
    // Register bus master: hold until waitrequest is sampled low at a rising edge
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check(32'(k < 50), 1, "register bus answer");
    endtask : av
    // Pin levels from logical chip select, strobe and direction
    task automatic pins(input logic c, input logic s, input logic r);
        hb_in.cs <= c ? cur.cs_pol : !cur.cs_pol;
        hb_in.rd <= cur.rw_mode ? (r ? !cur.rd_pol : cur.rd_pol) : ((s && r) ? cur.rd_pol : !cur.rd_pol);
        hb_in.wr <= cur.rw_mode ? (s ? cur.wr_pol : !cur.wr_pol) : ((s && !r) ? cur.wr_pol : !cur.wr_pol);
    endtask : pins
    // One host access; waits out a pending write, write data settles only late in the strobe
    task automatic hacc(input logic r, input logic [4:0] a, input logic [15:0] wd, output logic [15:0] q);
        int k;
        k = 0;
        @(posedge clk_sys);
        hb_in.addr <= a;
        hb_in.d <= r ? ~hb_in.d : wd;
        pins(1, 0, r);
        repeat (3) @(posedge clk_sys);
        do begin
            @(negedge clk_sys);
            k++;
        end while (hb_out.wait_ack === cur.wait_pol && k < 60);
        @(posedge clk_sys);
        pins(1, 1, r);
        if (!r) hb_in.d <= ~wd;
        repeat (2) @(posedge clk_sys);
        if (!r) hb_in.d <= wd;
        @(posedge clk_sys);
        do begin
            @(negedge clk_sys);
            k++;
        end while (r && hb_out.wait_ack !== !cur.wait_pol && k < 120);
        q = hb_out.d;
        if (r) check(32'(hb_out.d_oe), cur.bus16 ? 3 : 1, "lanes driven");
        @(posedge clk_sys);
        pins(0, 0, r);
        @(posedge clk_sys);
        hb_in.d <= ~hb_in.d;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check(32'(hb_out.d_oe), 0, "lanes released");
        check(32'(k < 120), 1, "host wait bound");
    endtask : hacc
    // Polarity change in two steps; chip select polarity moves last, with the strobes idle
    task automatic set_cfg(input hbp_setup_s s);
        logic [31:0] q;
        hbp_setup_s t;
        t = s;
        t.cs_pol = cur.cs_pol;
        av(1, AV_SETUP_OFS, 32'(t), q);
        cur = t;
        pins(0, 0, 0);
        cur = s;
        @(posedge clk_sys);
        pins(0, 0, 0);
        av(1, AV_SETUP_OFS, 32'(s), q);
    endtask : set_cfg
    task automatic t_regs();
        logic [31:0] q;
        logic [15:0] h;
        av(0, AV_SETUP_OFS, 0, q);
        check(32'(q[5:0]), 32'(SETUP_RESET), "setup reset");
        av(0, AV_HOSTCFG_OFS, 0, q);
        check(q, HOSTCFG_RESET, "host cfg reset");
        av(1, 4'hC, 32'hFFFF_FFFF, q);
        av(0, 4'hC, 0, q);
        check(q, 0, "unmapped");
        hacc(0, 5'h04, 16'h0055, h);
        hacc(1, 5'h04, 0, h);
        check(32'(h), 32'h0055, "word index in direction mode");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_word();
        logic [15:0] q;
        int n0;
        set_cfg(6'b100110);
        hacc(0, 5'h00, 16'h1234, q);
        hacc(1, 5'h00, 0, q);
        check(32'(q), 32'h1234, "cfg low word");
        hacc(0, 5'h04, 16'h0042, q);
        hacc(0, 5'h06, 16'hAB00, q);
        hacc(1, 5'h06, 0, q);
        check(32'(q), 0, "index top byte");
        hacc(1, 5'h04, 0, q);
        check(32'(q), 32'h0042, "index low word");
        n0 = u_regs.n_wr;
        hacc(0, 5'h0A, 16'hBEEF, q);
        check(u_regs.n_wr, n0, "no early write");
        hacc(0, 5'h08, 16'hCAFE, q);
        check(u_regs.mem[8'h42], 32'hBEEF_CAFE, "word assembly");
        check(32'(u_regs.last_addr), 32'h42, "routed address");
        hacc(1, 5'h08, 0, q);
        check(32'(q), 32'hCAFE, "read low word");
        hacc(1, 5'h0A, 0, q);
        check(32'(q), 32'hBEEF, "read high word");
        $display("t_word done");
    endtask : t_word
    task automatic t_byte_big();
        logic [15:0] q;
        logic [31:0] r;
        int n0;
        int ord [4] = '{3, 1, 0, 2};
        u_regs.delay = 6;
        set_cfg(6'b011001);
        hacc(0, 5'h00, 16'hA501, q);
        av(0, AV_HOSTCFG_OFS, 0, r);
        check(32'(r[0]), 1, "big endian set");
        for (int b = 0; b < 4; b++) begin
            hacc(0, 5'h0C + 5'(b), b == 3 ? 16'hA577 : 16'hA500 | 16'(b == 0 ? 8'hEE : 8'h00), q);
        end
        hacc(1, 5'h0F, 0, q);
        check(32'(q[7:0]), 32'h77, "index via lane 0");
        hacc(1, 5'h0C, 0, q);
        check(32'(q[7:0]), 0, "reserved byte");
        n0 = u_regs.n_wr;
        for (int i = 0; i < 4; i++) begin
            if (i == 3) check(u_regs.n_wr, n0, "partial dword held");
            hacc(0, 5'h10 + 5'(ord[i]), 16'h5A10 + 16'(ord[i]), q);
        end
        // The model answers late; wait for the posted write to land
        for (int k = 0; k < 40 && u_regs.n_wr == n0; k++) begin
            @(posedge clk_sys);
        end
        check(u_regs.n_wr, n0 + 1, "one internal write");
        check(u_regs.mem[8'h77], 32'h1011_1213, "big lane map");
        for (int b = 0; b < 4; b++) begin
            hacc(1, 5'h10 + 5'(b), 0, q);
            check(32'(q[7:0]), 32'h10 + b, "byte readback");
        end
        $display("t_byte_big done");
    endtask : t_byte_big
    // Stimulus, reset and verdict
    initial begin
        n_fail = 0;
        n_checks = 0;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_byteenable = 4'hF;
        avs_writedata = 32'h0;
        cur = SETUP_RESET;
        hb_in = '{cs: !cur.cs_pol, rd: cur.rw_mode ? cur.rd_pol : !cur.rd_pol, wr: !cur.wr_pol, addr: 5'h00, d: 16'h0};
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_word();
        t_byte_big();
        complete_run();
    end
    // Watchdog against a hang
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire
